// ===== rtl/rrc_classify.sv
// Purpose: Classifies received UDP/RTP packets of one connection and builds event reports.
// Assumes: Header fields arrive parsed, one packet per pkt_valid pulse.
// Notes:   Results appear one cycle after pkt_valid.
// Functional notes
// - Decode four-bit voice coding info.
// - Channel pointer counts in 32-byte units.
// - RTP index is marker over payload kind.
// - Non-RTP index is saturated payload length.
// - Table entry picks one of 16 channels.
// - First packet raises initialization flag.
// - Non-incremental sequence raises loss flag.
// - Entry report bit raises payload-report flag.
// - Short packet flagged and discarded whole when RTP enabled.
// - RTP version other than 2 flagged.
// - Failed UDP checksum flagged.
// - Report carries connection base address.
// - Report carries marker and payload kind.
// - Report carries length saturated at 255.
// - Report carries previous and current sequence.
// - Previous sequence only when RTP enabled.
// - Report carries local TDM time stamp.
// - Protocol bit selects indexing method.
// - Decode channel type, delete skips channel.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "rrc_defines.svh"
module rrc_classify
  import rrc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Register port
  input  wire logic [`RRC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Received packet
  input  wire logic                   pkt_valid,
  input  wire logic [15:0]            pkt_udp_len,
  input  wire logic                   pkt_marker,
  input  wire logic [6:0]             pkt_payload_kind,
  input  wire logic [1:0]             pkt_version,
  input  wire logic [15:0]            pkt_seq,
  input  wire logic                   pkt_csum_ok,
  input  wire logic [31:0]            tdm_timestamp,
  // Delivery
  output logic                        dlv_valid,
  output logic                        dlv_discard,
  output logic      [7:0]             dlv_index,
  output logic      [3:0]             dlv_channel_num,
  output rrc_chan_e                   dlv_chan_type,
  output logic      [20:0]            dlv_chan_addr,
  output rrc_voice_e                  dlv_voice_mode,
  output logic                        dlv_voice_reserved,
  // Event report
  output logic                        rpt_valid,
  output logic                        rpt_init,
  output logic                        rpt_loss,
  output logic                        rpt_payload_report,
  output logic                        short_header_error,
  output logic                        version_mismatch_error,
  output logic                        checksum_error_flag,
  output logic      [31:0]            rpt_conn_base,
  output logic                        rpt_marker,
  output logic      [6:0]             rpt_payload_kind,
  output logic      [7:0]             rpt_udp_len,
  output logic      [15:0]            rpt_prev_seq,
  output logic      [15:0]            rpt_cur_seq,
  output logic      [31:0]            rpt_timestamp
);

  // ==========================================================================
  // Configuration storage
  logic [31:0]            ctrl_reg;
  logic [31:0]            conn_base_reg;
  logic [3:0]             table_reg [256];
  logic [`RRC_SPL_W-1:0]  split_reg [16];
  logic                   init_done_reg;
  logic [15:0]            last_seq_reg;
  logic [15:0]            pkt_count_reg;

  wire rtp_en    = ctrl_reg[`RRC_CTRL_RTP];
  wire loss_en   = ctrl_reg[`RRC_CTRL_LOSS];
  wire csum_rpt  = ctrl_reg[`RRC_CTRL_CSUM_RPT];
  wire csum_disc = ctrl_reg[`RRC_CTRL_CSUM_DISC];

  // ==========================================================================
  // Register decode
  wire       sel_table = (reg_addr[11:10] == `RRC_TABLE_TAG);
  wire       sel_split = (reg_addr[11:6] == `RRC_SPLIT_TAG);
  wire [7:0] tab_widx  = reg_addr[9:2];
  wire [3:0] spl_widx  = reg_addr[5:2];
  wire       wr_ctrl   = reg_wr & (reg_addr == `RRC_OFF_CTRL);
  wire       wr_conn   = reg_wr & (reg_addr == `RRC_OFF_CONN_BASE);
  wire       restart   = wr_ctrl & reg_wdata[`RRC_CTRL_RESTART];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_table) begin
      rd_mux = {28'h000_0000, table_reg[tab_widx]};
    end else if (sel_split) begin
      rd_mux = {8'h00, split_reg[spl_widx]};
    end else if (reg_addr == `RRC_OFF_CTRL) begin
      rd_mux = {28'h000_0000, ctrl_reg[3:0]};
    end else if (reg_addr == `RRC_OFF_STATUS) begin
      rd_mux = {pkt_count_reg, last_seq_reg[14:0], init_done_reg};
    end else if (reg_addr == `RRC_OFF_CONN_BASE) begin
      rd_mux = conn_base_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg      <= `RRC_CTRL_RST;
      conn_base_reg <= `RRC_CONN_RST;
      reg_rdata     <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {28'h000_0000, reg_wdata[3:0]};
      end
      if (wr_conn) begin
        conn_base_reg <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_table
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          table_reg[gi] <= 4'h0;
        end else if (reg_wr && sel_table && tab_widx == 8'(gi)) begin
          table_reg[gi] <= reg_wdata[3:0];
        end
      end
    end
    for (gi = 0; gi < 16; gi++) begin : g_split
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          split_reg[gi] <= {`RRC_SPL_W{1'b0}};
        end else if (reg_wr && sel_split && spl_widx == 4'(gi)) begin
          split_reg[gi] <= reg_wdata[`RRC_SPL_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Lookup
  logic [7:0] index_w;
  logic [7:0] len_sat_w;

  rrc_index_calc u_index (
    .rtp_mode     (rtp_en),
    .marker       (pkt_marker),
    .payload_kind (pkt_payload_kind),
    .udp_len      (pkt_udp_len),
    .index        (index_w),
    .len_sat      (len_sat_w)
  );

  wire [3:0]            chan_w  = table_reg[index_w];
  wire [`RRC_SPL_W-1:0] entry_w = split_reg[chan_w];
  wire rrc_chan_e       type_w  = rrc_chan_e'(entry_w[`RRC_SPL_TYPE_HI:`RRC_SPL_TYPE_LO]);

  rrc_voice_e voice_w;
  logic       voice_rsv_w;

  rrc_voice_decode u_voice (
    .voice_coding_info (entry_w[`RRC_SPL_VOICE_HI:`RRC_SPL_VOICE_LO]),
    .voice_mode        (voice_w),
    .is_reserved       (voice_rsv_w)
  );

  // ==========================================================================
  // Packet checks
  wire        short_w    = rtp_en & (pkt_udp_len < `RRC_RTP_HDR_BYTES);
  wire        ver_bad_w  = rtp_en & ~short_w & (pkt_version != `RRC_RTP_VERSION);
  wire        csum_bad_w = ~pkt_csum_ok & csum_rpt;
  wire        ucd_drop_w = ~pkt_csum_ok & csum_disc;
  wire        upd_w      = pkt_valid & ~short_w & ~ucd_drop_w;
  wire        init_w     = upd_w & ~init_done_reg;
  wire [15:0] seq_inc_w  = last_seq_reg + 16'h0001;
  wire        loss_w     = upd_w & init_done_reg & rtp_en & loss_en
                         & (pkt_seq != seq_inc_w);
  wire        rep_w      = ~short_w & ~ucd_drop_w & entry_w[`RRC_SPL_REPORT];
  wire        delete_w   = (type_w == RRC_CH_DELETE);
  wire        drop_w     = short_w | ucd_drop_w | delete_w;
  wire        any_flag_w = init_w | loss_w | rep_w | short_w | ver_bad_w | csum_bad_w;

  // ==========================================================================
  // Connection state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_done_reg <= 1'b0;
      last_seq_reg  <= 16'h0000;
      pkt_count_reg <= 16'h0000;
    end else begin
      // A packet taken in the restart cycle keeps the connection initialized.
      init_done_reg <= upd_w ? 1'b1 : (restart ? 1'b0 : init_done_reg);
      if (upd_w && rtp_en) begin
        last_seq_reg <= pkt_seq;
      end
      if (upd_w) begin
        pkt_count_reg <= pkt_count_reg + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Delivery and report outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dlv_valid          <= 1'b0;
      dlv_discard        <= 1'b0;
      dlv_index          <= 8'h00;
      dlv_channel_num    <= 4'h0;
      dlv_chan_type      <= RRC_CH_VOICE;
      dlv_chan_addr      <= 21'h00_0000;
      dlv_voice_mode     <= RRC_VM_PCM64;
      dlv_voice_reserved <= 1'b0;
    end else begin
      dlv_valid   <= pkt_valid & ~drop_w;
      dlv_discard <= pkt_valid & drop_w;
      if (pkt_valid) begin
        dlv_index          <= index_w;
        dlv_channel_num    <= chan_w;
        dlv_chan_type      <= type_w;
        dlv_chan_addr      <= {entry_w[`RRC_SPL_PTR_HI:0], 5'h00};
        dlv_voice_mode     <= voice_w;
        dlv_voice_reserved <= voice_rsv_w;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rpt_valid              <= 1'b0;
      rpt_init               <= 1'b0;
      rpt_loss               <= 1'b0;
      rpt_payload_report     <= 1'b0;
      short_header_error     <= 1'b0;
      version_mismatch_error <= 1'b0;
      checksum_error_flag    <= 1'b0;
      rpt_conn_base          <= 32'h0000_0000;
      rpt_marker             <= 1'b0;
      rpt_payload_kind       <= 7'h00;
      rpt_udp_len            <= 8'h00;
      rpt_prev_seq           <= 16'h0000;
      rpt_cur_seq            <= 16'h0000;
      rpt_timestamp          <= 32'h0000_0000;
    end else begin
      rpt_valid              <= pkt_valid & any_flag_w;
      rpt_init               <= pkt_valid & init_w;
      rpt_loss               <= pkt_valid & loss_w;
      rpt_payload_report     <= pkt_valid & rep_w;
      short_header_error     <= pkt_valid & short_w;
      version_mismatch_error <= pkt_valid & ver_bad_w;
      checksum_error_flag    <= pkt_valid & csum_bad_w;
      if (pkt_valid) begin
        rpt_conn_base    <= conn_base_reg;
        rpt_marker       <= pkt_marker;
        rpt_payload_kind <= pkt_payload_kind;
        rpt_udp_len      <= len_sat_w;
        rpt_prev_seq     <= rtp_en ? last_seq_reg : 16'h0000;
        rpt_cur_seq      <= pkt_seq;
        rpt_timestamp    <= tdm_timestamp;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rtp_index;
    pkt_valid && rtp_en |=> dlv_index == {$past(pkt_marker), $past(pkt_payload_kind)};
  endproperty
  a_rtp_index: assert property (p_rtp_index) else $error("RTP index wrong");

  property p_len_index;
    pkt_valid && !rtp_en && pkt_udp_len >= 16'h00FF |=> dlv_index == 8'hFF;
  endproperty
  a_len_index: assert property (p_len_index) else $error("long index wrong");

  property p_short;
    pkt_valid && rtp_en && pkt_udp_len < 16'h000C |=> short_header_error && rpt_valid
      && !dlv_valid;
  endproperty
  a_short: assert property (p_short) else $error("short packet not dropped");

  property p_version;
    pkt_valid && rtp_en && pkt_udp_len >= 16'h000C && pkt_version != 2'h2
      |=> version_mismatch_error && rpt_valid;
  endproperty
  a_version: assert property (p_version) else $error("version not flagged");

  property p_csum;
    pkt_valid && !pkt_csum_ok && csum_rpt |=> checksum_error_flag && rpt_valid;
  endproperty
  a_csum: assert property (p_csum) else $error("checksum not flagged");

  property p_init;
    pkt_valid && !init_done_reg && !short_w && !ucd_drop_w |=> rpt_init ##1 !rpt_init;
  endproperty
  a_init: assert property (p_init) else $error("init flag wrong");

  property p_delete;
    pkt_valid && delete_w |=> dlv_discard && !dlv_valid;
  endproperty
  a_delete: assert property (p_delete) else $error("deleted packet delivered");

  property p_sat;
    pkt_valid && pkt_udp_len > 16'h00FF |=> rpt_udp_len == 8'hFF;
  endproperty
  a_sat: assert property (p_sat) else $error("length not saturated");

  property p_prev_seq;
    pkt_valid && !rtp_en |=> rpt_prev_seq == 16'h0000;
  endproperty
  a_prev_seq: assert property (p_prev_seq) else $error("previous sequence leaked");

  property p_ptr_align;
    dlv_valid |-> dlv_chan_addr[4:0] == 5'h00 && $past(pkt_valid);
  endproperty
  a_ptr_align: assert property (p_ptr_align) else $error("pointer not 32-byte");

endmodule

// ===== rtl/rrc_defines.svh
// Purpose: Offsets, field positions, reset values and fixed figures of the RTP classifier.
// Assumes: Register port with 12-bit byte addresses and 32-bit data.
// Notes:   Definitions only.
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH

// ==========================================================================
// Register map
`define RRC_ADDR_W         12
`define RRC_OFF_CTRL       12'h000
`define RRC_OFF_STATUS     12'h004
`define RRC_OFF_CONN_BASE  12'h008
`define RRC_SPLIT_TAG      6'h04
`define RRC_TABLE_TAG      2'h1
`define RRC_CTRL_RST       32'h0000_0000
`define RRC_CONN_RST       32'h0000_0000

// ==========================================================================
// Control bits
`define RRC_CTRL_RTP       0
`define RRC_CTRL_LOSS      1
`define RRC_CTRL_CSUM_RPT  2
`define RRC_CTRL_CSUM_DISC 3
`define RRC_CTRL_RESTART   8

// ==========================================================================
// Split entry layout
`define RRC_SPL_PTR_HI     15
`define RRC_SPL_TYPE_LO    16
`define RRC_SPL_TYPE_HI    18
`define RRC_SPL_VOICE_LO   19
`define RRC_SPL_VOICE_HI   22
`define RRC_SPL_REPORT     23
`define RRC_SPL_W          24

// ==========================================================================
// Packet figures
`define RRC_RTP_HDR_BYTES  16'h000C
`define RRC_RTP_VERSION    2'h2
`define RRC_LEN_SAT        8'hFF
`define RRC_PTR_SHIFT      5

`endif

// ===== rtl/rrc_pkg.sv
// Purpose: Types shared by the RTP classifier modules.
// Assumes: Nothing.
// Notes:   Constants live in rrc_defines.svh.
package rrc_pkg;

  typedef enum logic [2:0] {
    RRC_CH_VOICE  = 3'h0,
    RRC_CH_HDLC   = 3'h1,
    RRC_CH_CPU    = 3'h2,
    RRC_CH_DELETE = 3'h7
  } rrc_chan_e;

  typedef enum logic [3:0] {
    RRC_VM_PCM64     = 4'h0,
    RRC_VM_ADPCM40   = 4'h1,
    RRC_VM_ADPCM32   = 4'h2,
    RRC_VM_ADPCM24   = 4'h3,
    RRC_VM_ADPCM16   = 4'h4,
    RRC_VM_PCM_U2A   = 4'h8,
    RRC_VM_PCM_A2U   = 4'h9,
    RRC_VM_PCM_A2U_X = 4'hA,
    RRC_VM_PCM_U2U_X = 4'hB,
    RRC_VM_NOISE_EXT = 4'hC,
    RRC_VM_RESERVED  = 4'hF
  } rrc_voice_e;

endpackage

// ===== rtl/rrc_index_calc.sv
// Purpose: Forms the 8-bit lookup index of a received packet.
// Assumes: Payload length is in bytes.
// Notes:   Purely combinational.
`timescale 1ns/10ps
`include "rrc_defines.svh"
module rrc_index_calc
  import rrc_pkg::*;
(
  // Selection
  input  wire logic        rtp_mode,
  // Packet fields
  input  wire logic        marker,
  input  wire logic [6:0]  payload_kind,
  input  wire logic [15:0] udp_len,
  // Results
  output logic      [7:0]  index,
  output logic      [7:0]  len_sat
);

  wire long_len = (udp_len >= {8'h00, `RRC_LEN_SAT});

  assign len_sat = long_len ? `RRC_LEN_SAT : udp_len[7:0];
  assign index   = rtp_mode ? {marker, payload_kind} : len_sat;

endmodule

// ===== rtl/rrc_voice_decode.sv
// Purpose: Decodes the voice coding info of a channel entry.
// Assumes: Four-bit code.
// Notes:   Unlisted codes map to the reserved value.
`timescale 1ns/10ps
module rrc_voice_decode
  import rrc_pkg::*;
(
  // Code in
  input  wire logic [3:0] voice_coding_info,
  // Decoded
  output rrc_voice_e      voice_mode,
  output logic            is_reserved
);

  always_comb begin
    voice_mode  = RRC_VM_RESERVED;
    is_reserved = 1'b0;
    unique case (voice_coding_info)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC: voice_mode = rrc_voice_e'(voice_coding_info);
      default: is_reserved = 1'b1;
    endcase
  end

endmodule

// ===== sim/rrc_net_model.sv
// Purpose: Network side model that hands parsed UDP/RTP packets to the classifier.
// Assumes: At most one packet per cycle; fields qualify pkt_valid.
// Notes:   Between packets length, marker, payload kind, sequence and time stamp are inverted so stale values never pass as fresh.
`timescale 1ns/10ps
module rrc_net_model (
  // Clock
  input  wire logic        clk,
  // Packet out
  output logic             pkt_valid,
  output logic      [15:0] pkt_udp_len,
  output logic             pkt_marker,
  output logic      [6:0]  pkt_payload_kind,
  output logic      [1:0]  pkt_version,
  output logic      [15:0] pkt_seq,
  output logic             pkt_csum_ok,
  output logic      [31:0] tdm_timestamp
);
  initial begin
    {pkt_valid, pkt_udp_len, pkt_marker, pkt_payload_kind} = '0;
    {pkt_version, pkt_seq, pkt_csum_ok, tdm_timestamp} = '0;
  end

  // ==========================================================================
  // Transfers
  task automatic send(input logic [15:0] len, input logic [7:0] mk, input logic [1:0] ver,
                      input logic [15:0] seq, input logic ok, input logic [31:0] ts);
    pkt_valid <= 1'b1;
    pkt_udp_len <= len;
    {pkt_marker, pkt_payload_kind} <= mk;
    pkt_version <= ver;
    pkt_seq <= seq;
    pkt_csum_ok <= ok;
    tdm_timestamp <= ts;
    @(posedge clk);
  endtask

  task automatic idle();
    pkt_valid <= 1'b0;
    pkt_udp_len <= ~pkt_udp_len;
    {pkt_marker, pkt_payload_kind} <= ~{pkt_marker, pkt_payload_kind};
    pkt_seq <= ~pkt_seq;
    tdm_timestamp <= ~tdm_timestamp;
    @(posedge clk);
  endtask
endmodule

// ===== sim/rx_rtp_classify_and_report_bench.sv
// Purpose: Self-checking bench of the RTP classifier against a behavioural model.
// Assumes: Register port and packet timing as in the hand-over contract.
// Notes:   Packets are random from an xorshift source, except six fixed edge-length packets; channel fields are compared only for accepted or delivered packets.
`timescale 1ns/10ps
`include "rrc_defines.svh"
module rx_rtp_classify_and_report_bench import rrc_pkg::*;;
  logic clk, reset_n, reg_wr, reg_rd, pkt_valid, pkt_marker, pkt_csum_ok;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, tdm_timestamp, rpt_conn_base, rpt_timestamp;
  logic [15:0] pkt_udp_len, pkt_seq, rpt_prev_seq, rpt_cur_seq;
  logic [6:0] pkt_payload_kind, rpt_payload_kind;
  logic [1:0] pkt_version;
  logic dlv_valid, dlv_discard, dlv_voice_reserved, rpt_valid, rpt_init, rpt_loss;
  logic rpt_payload_report, short_header_error, version_mismatch_error, checksum_error_flag;
  logic rpt_marker;
  logic [7:0] dlv_index, rpt_udp_len;
  logic [3:0] dlv_channel_num;
  logic [20:0] dlv_chan_addr;
  rrc_chan_e dlv_chan_type;
  rrc_voice_e dlv_voice_mode;
  logic [3:0] m_tbl [256];
  logic [23:0] m_spl [16];
  logic [31:0] m_ctrl, m_base, rng;
  logic [15:0] m_last, m_cnt, q;
  logic m_init;
  int n_mismatch, total_checks;
  logic [15:0] edge_len [6] = '{16'd0, 16'd1, 16'd254, 16'd255, 16'd256, 16'd1500};

  rrc_classify u_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pkt_valid, .pkt_udp_len, .pkt_marker, .pkt_payload_kind, .pkt_version, .pkt_seq,
    .pkt_csum_ok, .tdm_timestamp, .dlv_valid, .dlv_discard, .dlv_index, .dlv_channel_num,
    .dlv_chan_type, .dlv_chan_addr, .dlv_voice_mode, .dlv_voice_reserved, .rpt_valid,
    .rpt_init, .rpt_loss, .rpt_payload_report, .short_header_error, .version_mismatch_error,
    .checksum_error_flag, .rpt_conn_base, .rpt_marker, .rpt_payload_kind, .rpt_udp_len,
    .rpt_prev_seq, .rpt_cur_seq, .rpt_timestamp);
  rrc_net_model u_net (.clk, .pkt_valid, .pkt_udp_len, .pkt_marker, .pkt_payload_kind,
    .pkt_version, .pkt_seq, .pkt_csum_ok, .tdm_timestamp);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_dlv(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_rpt(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
    if (a == `RRC_OFF_CTRL) m_ctrl = d & 32'h0000_000F;
    if (a == `RRC_OFF_CTRL && d[`RRC_CTRL_RESTART]) m_init = 1'b0;
    if (a == `RRC_OFF_CONN_BASE) m_base = d;
    if (a[11:6] == `RRC_SPLIT_TAG) m_spl[a[5:2]] = d[23:0];
    if (a[11:10] == `RRC_TABLE_TAG) m_tbl[a[9:2]] = d[3:0];
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_reg(reg_rdata, exp);
    @(posedge clk);
  endtask

  task automatic run(input int n);
    logic [31:0] r;
    logic [15:0] len;
    for (int i = 0; i < n; i++) begin
      r = xs();
      len = (r[2:0] == 3'h0) ? 16'(r[7:4]) + 16'h0004 : 16'(r[18:8] % 11'd1500);
      q = (r[31:29] == 3'h0) ? q + 16'(r[28:26]) + 16'h0002 : q + 16'h0001;
      u_net.send(len, 8'(xs() >> 24), (r[25:23] == 3'h0) ? r[22:21] : 2'h2, q,
                 (len < 16'h000C) || (r[20:19] != 2'h0), xs());
      if (r[9]) u_net.idle();
    end
    u_net.idle();
  endtask

  // ==========================================================================
  // Reference model and packet result comparison, channel fields only for accepted or delivered packets
  always @(posedge clk) begin : model
    logic rtp, shrt, acc, disc;
    logic [7:0] idx, ls;
    logic [23:0] e;
    logic [3:0] ch, vc, ve;
    logic [5:0] f;
    logic [15:0] ps, cs;
    logic [31:0] ts;
    logic [7:0] mk;
    if (reset_n && pkt_valid) begin
      rtp = m_ctrl[`RRC_CTRL_RTP];
      ls = (pkt_udp_len > 16'h00FF) ? 8'hFF : pkt_udp_len[7:0];
      idx = rtp ? {pkt_marker, pkt_payload_kind} : ls;
      ch = m_tbl[idx];
      e = m_spl[ch];
      shrt = rtp && (pkt_udp_len < 16'h000C);
      acc = !shrt && !(!pkt_csum_ok && m_ctrl[`RRC_CTRL_CSUM_DISC]);
      f[5] = acc && !m_init;
      f[4] = acc && m_init && rtp && m_ctrl[1] && (pkt_seq != m_last + 16'h0001);
      f[3] = acc && e[23];
      f[2] = shrt;
      f[1] = rtp && !shrt && (pkt_version != 2'h2);
      f[0] = !pkt_csum_ok && m_ctrl[`RRC_CTRL_CSUM_RPT];
      vc = e[22:19];
      ve = (vc < 4'h5 || (vc >= 4'h8 && vc <= 4'hC)) ? vc : 4'hF;
      disc = !acc || (e[18:16] == 3'h7);
      ps = rtp ? m_last : 16'h0000;
      cs = pkt_seq;
      ts = tdm_timestamp;
      mk = {pkt_marker, pkt_payload_kind};
      if (acc) begin
        m_init = 1'b1;
        if (rtp) m_last = pkt_seq;
        m_cnt++;
      end
      #1;
      chk_dlv(dlv_valid, !disc);
      chk_dlv(dlv_discard, disc);
      chk_dlv(dlv_index, idx);
      chk_rpt(rpt_valid, |f);
      chk_rpt({rpt_init, rpt_loss, rpt_payload_report, short_header_error,
           version_mismatch_error, checksum_error_flag}, f);
      chk_rpt(rpt_conn_base, m_base);
      chk_rpt({rpt_marker, rpt_payload_kind}, mk);
      chk_rpt(rpt_udp_len, ls);
      chk_rpt(rpt_prev_seq, ps);
      chk_rpt(rpt_cur_seq, cs);
      chk_rpt(rpt_timestamp, ts);
      if (acc) chk_dlv(dlv_channel_num, ch);
      if (acc) chk_dlv(dlv_chan_type, e[18:16]);
      if (!disc) chk_dlv(dlv_chan_addr, {e[15:0], 5'h00});
      if (!disc) chk_dlv(dlv_voice_mode, ve);
      if (!disc) chk_dlv(dlv_voice_reserved, ve == 4'hF);
    end
  end

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {m_ctrl, m_base, m_last, m_cnt, m_init, n_mismatch, total_checks} = '0;
    rng = 32'd86860;
    q = 16'hFFF0;
    for (int k = 0; k < 256; k++) m_tbl[k] = 4'h0;
    for (int k = 0; k < 16; k++) m_spl[k] = 24'h00_0000;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`RRC_OFF_CTRL, `RRC_CTRL_RST);
    rd(`RRC_OFF_CONN_BASE, `RRC_CONN_RST);
    rd(`RRC_OFF_STATUS, 32'h0000_0000);
    wr(12'h00C, 32'hFFFF_FFFF);
    rd(12'h00C, 32'h0000_0000);
    wr(`RRC_OFF_CONN_BASE, xs());
    for (int k = 0; k < 16; k++)
      wr(12'h100 + 12'(4 * k), {k[0], k[3:0], (k == 7) ? 3'h7 : 3'(k % 3), 16'(xs())});
    for (int k = 0; k < 256; k++) wr(12'h400 + 12'(4 * k), xs() & 32'h0000_000F);
    wr(`RRC_OFF_CTRL, 32'h0000_0007);
    rd(`RRC_OFF_CTRL, 32'h0000_0007);
    rd(`RRC_OFF_CONN_BASE, m_base);
    run(300);
    wr(`RRC_OFF_CTRL, 32'h0000_010F);
    rd(`RRC_OFF_STATUS, {m_cnt, m_last[14:0], m_init});
    run(150);
    wr(`RRC_OFF_CTRL, 32'h0000_0004);
    rd(`RRC_OFF_STATUS, {m_cnt, m_last[14:0], m_init});
    foreach (edge_len[j])
      u_net.send(edge_len[j], 8'h00, 2'h2, 16'h0001, 1'b1, xs());
    run(150);
    rd(`RRC_OFF_STATUS, {m_cnt, m_last[14:0], m_init});
    conclude();
  end
endmodule
